/* File: design/fantp_pkg.sv */
package fantp_pkg;
    localparam int NFAN  = 4;
    localparam int NTACH = 5;

    // Register indices; the APB byte address is index * 4
    localparam logic [NFAN-1:0][9:0]  FREQ_IDX  = {10'h060, 10'h010, 10'h002, 10'h000};
    localparam logic [NFAN-1:0][9:0]  VAL_IDX   = {10'h061, 10'h011, 10'h003, 10'h001};
    localparam logic [NTACH-1:0][9:0] CNT_IDX   = {10'h053, 10'h03f, 10'h02a, 10'h029, 10'h028};
    localparam logic [NTACH-1:0][9:0] DIV_IDX   = {10'h074, 10'h073, 10'h072, 10'h071, 10'h070};
    localparam logic [NFAN-1:0][9:0]  TBASE_IDX = {10'h07b, 10'h07a, 10'h079, 10'h078};
    localparam logic [NFAN-1:0][9:0]  TEMP_IDX  = {10'h07f, 10'h07e, 10'h07d, 10'h07c};
    localparam logic [9:0]            MODE_IDX  = 10'h080;
    localparam logic [9:0]            BRG_IDX   = 10'h081;
    localparam logic [9:0]            QLO_IDX   = 10'h082;
    localparam logic [9:0]            QHI_IDX   = 10'h083;
    localparam logic [9:0]            RAWLO_IDX = 10'h084;
    localparam logic [9:0]            RAWHI_IDX = 10'h085;
    localparam logic [9:0]            STAT_IDX  = 10'h086;

    // Reset values
    localparam logic [7:0]  VAL_RST   = 8'hff;
    localparam logic [7:0]  FREQ_RST  = 8'h04;
    localparam logic [2:0]  DIV_RST   = 3'h1;
    localparam logic [15:0] QTR_RST   = 16'h007c;

    // Field positions
    localparam int DAC_LSB  = 2;
    localparam int TEMP_LSB = 6;
    localparam int STAT_ST  = 4;

    // Timing
    localparam int CLK_MHZ       = 250;
    localparam int TACH_REF_HZ   = 22500;
    localparam int TACH_TICK_CYC = CLK_MHZ * 1000000 / TACH_REF_HZ;
    localparam int PECI_POLL_US  = 1000;
    localparam int PECI_POLL_CYC = PECI_POLL_US * CLK_MHZ;
    localparam int BASE_W        = 24;
    localparam int POLL_W        = 24;
    localparam int PWM_PRESCALE  = 4;
    localparam logic [7:0] PWM_LAST = 8'hfe;

    // Fixed temperature request: two timing bits, address, lengths, command, check byte
    localparam int PECI_TX_BITS = 42;
    localparam int PECI_RX_BITS = 24;
    localparam logic [7:0] PECI_FCS = 8'h00;
    localparam logic [PECI_TX_BITS-1:0] PECI_TX = {2'h3, 8'h30, 8'h01, 8'h02, 8'h01, PECI_FCS};

    typedef enum logic [3:0] {
        P_IDLE = 4'h1,
        P_TX   = 4'h2,
        P_RX   = 4'h4,
        P_BRG  = 4'h8
    } fantp_peci_st_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } fantp_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } fantp_apb_rsp_t;
endpackage : fantp_pkg

/* File: design/fantp_fan_out.sv */
`timescale 1ns/10ps
module fantp_fan_out #(
    parameter int PRESCALE = fantp_pkg::PWM_PRESCALE
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [7:0] freq,
    input  wire logic [7:0] val,
    input  wire logic       dcMode,
    output logic            pwmOut,
    output logic [5:0]      dacCode
);
    typedef struct packed {
        logic [15:0] pre;
        logic [7:0]  step;
        logic        out;
        logic [5:0]  dac;
    } fantp_fan_state_t;

    fantp_fan_state_t s_q;
    fantp_fan_state_t s_d;
    logic [15:0]      lim;
    logic             stepTick;

    // Step length grows with the frequency code, so a larger code means a slower period
    assign lim      = 16'((16'(freq) + 16'h0001) * 16'(PRESCALE) - 16'h0001);
    // Not an equality test: a shorter step after a frequency write would else wait for the prescaler to wrap
    assign stepTick = (s_q.pre >= lim);

    always_comb begin
        s_d     = s_q;
        s_d.pre = stepTick ? 16'h0000 : s_q.pre + 16'h0001;
        if (stepTick) begin
            s_d.step = (s_q.step >= fantp_pkg::PWM_LAST) ? 8'h00 : s_q.step + 8'h01;
        end
        s_d.out = ~dcMode & (s_q.step < val);
        s_d.dac = dcMode ? val[7:fantp_pkg::DAC_LSB] : 6'h00;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q     <= '0;
            s_q.out <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign pwmOut  = s_q.out;
    assign dacCode = s_q.dac;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    step_range_a: assert property (s_q.step <= fantp_pkg::PWM_LAST)
        else $error("pwm step left the 255-step period");
    full_duty_a: assert property (!dcMode && val == 8'hff [*2] |-> pwmOut)
        else $error("full duty output went low");
    zero_duty_a: assert property (!dcMode && val == 8'h00 [*2] |-> !pwmOut)
        else $error("zero duty output went high");
    dac_code_a: assert property (dcMode [*2] |-> dacCode == $past(val[7:2]) && !pwmOut)
        else $error("dac code does not follow upper value bits");
endmodule : fantp_fan_out

/* File: design/fantp_top.sv */
`timescale 1ns/10ps
module fantp_top #(
    parameter int TACH_TICK = fantp_pkg::TACH_TICK_CYC,
    parameter int POLL_CYC  = fantp_pkg::PECI_POLL_CYC
) (
    input  wire logic                                 mclk,
    input  wire logic                                 rst,
    input  fantp_pkg::fantp_apb_req_t                 apbReq,
    output fantp_pkg::fantp_apb_rsp_t                 apbRsp,
    input  wire logic [fantp_pkg::NTACH-1:0]          tachIn,
    output logic [fantp_pkg::NFAN-1:0]                pwmOut,
    output logic [fantp_pkg::NFAN-1:0][5:0]           dacCode,
    output logic [fantp_pkg::NFAN-1:0][7:0]           fanTemp,
    input  wire logic                                 peciIn,
    output logic                                      peciOut,
    output logic                                      peciOe,
    input  wire logic                                 sidebandHostPinIn,
    output logic                                      sidebandHostPinOut,
    output logic                                      sidebandHostPinOe
);
    localparam int NF  = fantp_pkg::NFAN;
    localparam int NT  = fantp_pkg::NTACH;
    localparam int BW  = fantp_pkg::BASE_W;
    localparam int PW  = fantp_pkg::POLL_W;
    localparam int TXB = fantp_pkg::PECI_TX_BITS;
    localparam int RXB = fantp_pkg::PECI_RX_BITS;
    localparam int TL  = fantp_pkg::TEMP_LSB;

    typedef struct packed {
        logic [NF-1:0][7:0]        freq;
        logic [NF-1:0][7:0]        val;
        logic [NF-1:0][7:0]        tbase;
        logic [NF-1:0][7:0]        temp;
        logic [NF-1:0]             dcMode;
        logic                      bridge;
        logic [15:0]               qtr;
        logic [NT-1:0][2:0]        div;
        logic [NT-1:0][7:0]        run;
        logic [NT-1:0][7:0]        cnt;
        logic [NT-1:0][6:0]        pre;
        logic [NT-1:0]             tS1;
        logic [NT-1:0]             tS2;
        logic [NT-1:0]             tS3;
        logic [BW-1:0]             base;
        logic                      pS1;
        logic                      pS2;
        logic                      sS1;
        logic                      sS2;
        fantp_pkg::fantp_peci_st_t st;
        logic [PW-1:0]             poll;
        logic [15:0]               qCnt;
        logic [1:0]                qIdx;
        logic [5:0]                bitIdx;
        logic [RXB-1:0]            rx;
        logic [15:0]               raw;
        logic                      rxOk;
        logic                      pOut;
        logic                      pOe;
        logic                      sOut;
        logic                      sOe;
        logic [2:0]                pHist;
        logic [2:0]                sHist;
        logic [31:0]               prdata;
    } fantp_top_state_t;

    fantp_top_state_t s_q;
    fantp_top_state_t s_d;
    logic             tick;
    logic             qEnd;
    logic             txBit;
    logic             setup;
    logic             wr;
    logic             hit;
    logic [9:0]       idx;
    logic [31:0]      rd;
    logic [NT-1:0]    tachEdge;
    logic             hostEcho;
    logic             wireEcho;

    assign setup    = apbReq.psel & ~apbReq.penable;
    assign wr       = apbReq.psel & apbReq.penable & apbReq.pwrite;
    assign idx      = apbReq.paddr[11:2];
    assign tick     = (s_q.base == BW'(TACH_TICK - 1));
    assign qEnd     = (s_q.qCnt == s_q.qtr);
    assign tachEdge = s_q.tS2 & ~s_q.tS3;
    assign txBit    = fantp_pkg::PECI_TX[TXB - 1 - int'(s_q.bitIdx)];
    // Own drive reaches the far synchroniser a few cycles late; repeating it back would latch both sides high
    assign hostEcho = s_q.sOe | (|s_q.sHist);
    assign wireEcho = (s_q.pOe & s_q.pOut) | (|s_q.pHist);

    always_comb begin
        s_d = s_q;

        // Pins from outside pass two flops before use
        s_d.tS1 = tachIn;
        s_d.tS2 = s_q.tS1;
        s_d.tS3 = s_q.tS2;
        s_d.pS1 = peciIn;
        s_d.pS2 = s_q.pS1;
        s_d.sS1 = sidebandHostPinIn;
        s_d.sS2 = s_q.sS1;
        s_d.pHist = {s_q.pHist[1:0], s_q.pOe & s_q.pOut};
        s_d.sHist = {s_q.sHist[1:0], s_q.sOe};

        // Shared reference tick, each tach prescales it by its own divisor
        s_d.base = tick ? '0 : s_q.base + 1'b1;
        for (int i = 0; i < NT; i++) begin
            if (tick) begin
                if (s_q.pre[i] >= 7'((8'h01 << s_q.div[i]) - 8'h01)) begin
                    s_d.pre[i] = 7'h00;
                    // Saturate so a period over 255 prescaled ticks reads as the slowest speed; a stalled fan gives no edge and keeps its last count
                    if (s_q.run[i] != 8'hff) begin
                        s_d.run[i] = s_q.run[i] + 8'h01;
                    end
                end else begin
                    s_d.pre[i] = s_q.pre[i] + 7'h01;
                end
            end
            if (tachEdge[i]) begin
                s_d.cnt[i] = s_q.run[i];
                s_d.run[i] = 8'h00;
                s_d.pre[i] = 7'h00;
            end
        end

        // Integer part of the reading plus each base offset, wrapped to eight bits
        for (int i = 0; i < NF; i++) begin
            s_d.temp[i] = s_q.tbase[i] + s_q.raw[TL+7:TL];
        end

        // Quarter-bit timer; idle and bridge states keep it cleared
        if (qEnd || s_q.st == fantp_pkg::P_IDLE || s_q.st == fantp_pkg::P_BRG) begin
            s_d.qCnt = 16'h0000;
        end else begin
            s_d.qCnt = s_q.qCnt + 16'h0001;
        end
        s_d.sOut = 1'b0;
        s_d.sOe  = 1'b0;

        unique case (s_q.st)
            fantp_pkg::P_IDLE: begin
                s_d.pOut = 1'b0;
                s_d.pOe  = 1'b1;
                s_d.qIdx = 2'h0;
                s_d.bitIdx = 6'h00;
                // Bridge only takes over between frames, never cutting one short
                if (s_q.bridge) begin
                    s_d.st   = fantp_pkg::P_BRG;
                    s_d.poll = '0;
                end else if (s_q.poll == PW'(POLL_CYC - 1)) begin
                    s_d.st   = fantp_pkg::P_TX;
                    s_d.poll = '0;
                end else begin
                    s_d.poll = s_q.poll + 1'b1;
                end
            end
            fantp_pkg::P_TX: begin
                // Rising edge opens every bit; a one stays high three quarters
                s_d.pOe  = 1'b1;
                s_d.pOut = (s_q.qIdx == 2'h0) | (txBit & (s_q.qIdx != 2'h3));
                if (qEnd) begin
                    s_d.qIdx = s_q.qIdx + 2'h1;
                    if (s_q.qIdx == 2'h3) begin
                        s_d.bitIdx = s_q.bitIdx + 6'h01;
                        if (s_q.bitIdx == 6'(TXB - 1)) begin
                            s_d.st     = fantp_pkg::P_RX;
                            s_d.bitIdx = 6'h00;
                        end
                    end
                end
            end
            fantp_pkg::P_RX: begin
                // Master still makes the bit edge, then lets the client hold the wire
                s_d.pOe  = (s_q.qIdx == 2'h0);
                s_d.pOut = (s_q.qIdx == 2'h0);
                if (qEnd) begin
                    s_d.qIdx = s_q.qIdx + 2'h1;
                    if (s_q.qIdx == 2'h1) begin
                        s_d.rx = {s_q.rx[RXB-2:0], s_q.pS2};
                    end
                    if (s_q.qIdx == 2'h3) begin
                        s_d.bitIdx = s_q.bitIdx + 6'h01;
                        if (s_q.bitIdx == 6'(RXB - 1)) begin
                            s_d.st   = fantp_pkg::P_IDLE;
                            s_d.raw  = {s_q.rx[15:8], s_q.rx[23:16]};
                            s_d.rxOk = 1'b1;
                        end
                    end
                end
            end
            fantp_pkg::P_BRG: begin
                // Either side driving high is repeated; the host side wins a clash
                s_d.pOut = s_q.sS2 & ~hostEcho;
                s_d.pOe  = s_q.sS2 & ~hostEcho;
                s_d.sOut = s_q.pS2;
                s_d.sOe  = s_q.pS2 & ~s_q.sS2 & ~wireEcho;
                if (!s_q.bridge) begin
                    s_d.st = fantp_pkg::P_IDLE;
                end
            end
        endcase

        // Register file: zero wait, read data captured in the setup cycle
        hit = 1'b0;
        rd  = 32'h0000_0000;
        for (int i = 0; i < NF; i++) begin
            if (idx == fantp_pkg::FREQ_IDX[i]) begin
                hit = 1'b1;
                rd  = {24'h000000, s_q.freq[i]};
                if (wr) s_d.freq[i] = apbReq.pwdata[7:0];
            end
            if (idx == fantp_pkg::VAL_IDX[i]) begin
                hit = 1'b1;
                rd  = {24'h000000, s_q.val[i]};
                // Low bits are kept even in DC mode; the converter ignores them
                if (wr) s_d.val[i] = apbReq.pwdata[7:0];
            end
            if (idx == fantp_pkg::TBASE_IDX[i]) begin
                hit = 1'b1;
                rd  = {24'h000000, s_q.tbase[i]};
                if (wr) s_d.tbase[i] = apbReq.pwdata[7:0];
            end
            if (idx == fantp_pkg::TEMP_IDX[i]) begin
                hit = 1'b1;
                rd  = {24'h000000, s_q.temp[i]};
            end
        end
        for (int i = 0; i < NT; i++) begin
            if (idx == fantp_pkg::CNT_IDX[i]) begin
                hit = 1'b1;
                rd  = {24'h000000, s_q.cnt[i]};
            end
            if (idx == fantp_pkg::DIV_IDX[i]) begin
                hit = 1'b1;
                rd  = {29'h00000000, s_q.div[i]};
                if (wr) s_d.div[i] = apbReq.pwdata[2:0];
            end
        end
        if (idx == fantp_pkg::MODE_IDX) begin
            hit = 1'b1;
            rd  = {28'h0000000, s_q.dcMode};
            if (wr) s_d.dcMode = apbReq.pwdata[NF-1:0];
        end
        if (idx == fantp_pkg::BRG_IDX) begin
            hit = 1'b1;
            rd  = {31'h00000000, s_q.bridge};
            if (wr) s_d.bridge = apbReq.pwdata[0];
        end
        if (idx == fantp_pkg::QLO_IDX) begin
            hit = 1'b1;
            rd  = {24'h000000, s_q.qtr[7:0]};
            if (wr) s_d.qtr[7:0] = apbReq.pwdata[7:0];
        end
        if (idx == fantp_pkg::QHI_IDX) begin
            hit = 1'b1;
            rd  = {24'h000000, s_q.qtr[15:8]};
            if (wr) s_d.qtr[15:8] = apbReq.pwdata[7:0];
        end
        if (idx == fantp_pkg::RAWLO_IDX) begin
            hit = 1'b1;
            rd  = {24'h000000, s_q.raw[7:0]};
        end
        if (idx == fantp_pkg::RAWHI_IDX) begin
            hit = 1'b1;
            rd  = {24'h000000, s_q.raw[15:8]};
        end
        if (idx == fantp_pkg::STAT_IDX) begin
            hit = 1'b1;
            rd  = {24'h000000, s_q.st, 3'h0, s_q.rxOk};
        end
        if (setup) begin
            s_d.prdata = rd;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q        <= '0;
            s_q.freq   <= {NF{fantp_pkg::FREQ_RST}};
            s_q.val    <= {NF{fantp_pkg::VAL_RST}};
            s_q.div    <= {NT{fantp_pkg::DIV_RST}};
            s_q.qtr    <= fantp_pkg::QTR_RST;
            s_q.st     <= fantp_pkg::P_IDLE;
            s_q.pOe    <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    for (genvar g = 0; g < NF; g++) begin : g_fan
        fantp_fan_out u_out (
            .mclk    (mclk),
            .rst     (rst),
            .freq    (s_q.freq[g]),
            .val     (s_q.val[g]),
            .dcMode  (s_q.dcMode[g]),
            .pwmOut  (pwmOut[g]),
            .dacCode (dacCode[g])
        );
    end

    assign fanTemp            = s_q.temp;
    assign peciOut            = s_q.pOut;
    assign peciOe             = s_q.pOe;
    assign sidebandHostPinOut = s_q.sOut;
    assign sidebandHostPinOe  = s_q.sOe;
    assign apbRsp.prdata      = s_q.prdata;
    assign apbRsp.pready      = 1'b1;
    assign apbRsp.pslverr     = apbReq.psel & apbReq.penable & ~hit;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    master_drive_a: assert property (s_q.st == fantp_pkg::P_TX |=> peciOe)
        else $error("master not driving during request");
    rx_release_a: assert property (s_q.st == fantp_pkg::P_RX && s_q.qIdx != 2'h0 |=> !peciOe)
        else $error("master holds wire while client answers");
    temp_offset_a: assert property (s_q.rxOk
        |=> fanTemp[0] == 8'($past(s_q.tbase[0]) + $past(s_q.raw[13:6])))
        else $error("offset temperature wrong");
    bridge_pass_a: assert property (s_q.bridge && s_q.st == fantp_pkg::P_IDLE && !hostEcho
        |=> s_q.st == fantp_pkg::P_BRG ##1 peciOut == $past(s_q.sS2))
        else $error("bridge did not pass sideband level");
    tach_latch_a: assert property (tachEdge[0] |=> s_q.cnt[0] == $past(s_q.run[0]) && s_q.run[0] == 8'h00)
        else $error("tach period not latched");
    count_read_a: assert property (setup && !apbReq.pwrite && idx == fantp_pkg::CNT_IDX[4]
        |=> apbRsp.prdata == {24'h000000, $past(s_q.cnt[4])})
        else $error("fan count read wrong");
    div_reset_a: assert property ($past(rst) |-> s_q.div == {NT{fantp_pkg::DIV_RST}})
        else $error("divisor reset not two");
    prescale_a: assert property (tick && s_q.div[1] == 3'h0 && !tachEdge[1] && s_q.run[1] != 8'hff
        |=> s_q.run[1] == $past(s_q.run[1]) + 8'h01)
        else $error("divisor one did not count every tick");
    value_reset_a: assert property ($past(rst) |-> s_q.val == {NF{fantp_pkg::VAL_RST}})
        else $error("output value reset not all ones");

    bridge_c: cover property (s_q.st == fantp_pkg::P_BRG);
    reading_c: cover property ($rose(s_q.rxOk));
    tach_c: cover property (tachEdge[0] && s_q.run[0] != 8'h00);
endmodule : fantp_top

/* File: dv/fantp_fan_peci_model.sv */
`timescale 1ns/10ps
module fantp_fan_peci_model (
    input  wire logic  mclk,
    input  wire logic  rst,
    input  wire logic  peciOut,
    input  wire logic  peciOe,
    input  wire logic  sbOut,
    input  wire logic  sbOe,
    input  wire logic  hostDrv,
    output logic [4:0] tachIn,
    output logic       peciWire,
    output logic       sbWire
);
    logic [4:0][11:0] halfCnt;
    logic [6:0]       riseCnt;
    logic [5:0]       lowCnt;
    logic             lastOut;
    logic             ansBit;
    // Reply of -960 counts (16'hfc40, low byte first) and a check byte, sent MSB first
    localparam logic [23:0] REPLY = 24'h40fc00;
    initial begin
        tachIn  = 5'h00;
        halfCnt = '0;
        riseCnt = 7'h00;
        lowCnt  = 6'h00;
        lastOut = 1'b0;
    end
    // Each master bit opens with one rising edge; a long low drive marks the gap between frames
    always @(posedge mclk) begin
        lastOut <= peciOut;
        if (!peciOe || peciOut) begin
            lowCnt <= 6'h00;
        end else if (lowCnt != 6'h3f) begin
            lowCnt <= lowCnt + 6'h01;
        end
        if (rst) begin
            riseCnt <= 7'h00;
        end else if (peciOut && !lastOut) begin
            riseCnt <= (lowCnt == 6'h3f) ? 7'h01 : riseCnt + 7'h01;
        end
    end
    assign ansBit = (riseCnt >= 7'h2b && riseCnt <= 7'h42) ? REPLY[7'h42 - riseCnt] : 1'b0;
    // Half periods 200, 400 .. 1000 cycles, so each fan gives a distinct period
    always @(posedge mclk) begin
        for (int i = 0; i < 5; i++) begin
            if (rst || halfCnt[i] == 12'(200 * (i + 1) - 1)) begin
                halfCnt[i] <= 12'h000;
                tachIn[i]  <= rst ? 1'b0 : ~tachIn[i];
            end else begin
                halfCnt[i] <= halfCnt[i] + 12'h001;
            end
        end
    end
    // Client holds the released wire at its reply bit
    assign peciWire = peciOe ? peciOut : ansBit;
    assign sbWire   = sbOe ? sbOut : hostDrv;
endmodule : fantp_fan_peci_model

/* File: dv/tb_fan_tach_pwm_control.sv */
`timescale 1ns/10ps
module tb_fan_tach_pwm_control;
    logic                      mclk    = 1'b0;
    logic                      rst     = 1'b1;
    logic                      hostDrv = 1'b0;
    fantp_pkg::fantp_apb_req_t apbReq  = '0;
    fantp_pkg::fantp_apb_rsp_t apbRsp;
    logic [4:0]                tachIn;
    logic [3:0]                pwmOut;
    logic [3:0][5:0]           dacCode;
    logic [3:0][7:0]           fanTemp;
    logic                      peciWire, peciOut, peciOe, sbWire, sbOut, sbOe;
    logic [31:0]               rd;
    logic                      err;
    int                        miscompares = 0;
    int                        cmp_count   = 0;
    int                        cyc         = 0;

    initial forever #2 mclk = ~mclk;

    fantp_top #(.TACH_TICK(20), .POLL_CYC(200)) dut (
        .mclk(mclk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp), .tachIn(tachIn),
        .pwmOut(pwmOut), .dacCode(dacCode), .fanTemp(fanTemp), .peciIn(peciWire),
        .peciOut(peciOut), .peciOe(peciOe), .sidebandHostPinIn(sbWire),
        .sidebandHostPinOut(sbOut), .sidebandHostPinOe(sbOe));

    fantp_fan_peci_model model (
        .mclk(mclk), .rst(rst), .peciOut(peciOut), .peciOe(peciOe), .sbOut(sbOut),
        .sbOe(sbOe), .hostDrv(hostDrv), .tachIn(tachIn), .peciWire(peciWire), .sbWire(sbWire));

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Entered at a rising edge; leaves one idle cycle so strobes never double up
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'h0}, pwdata: wd};
        @(posedge mclk);
        apbReq.penable <= 1'b1;
        do @(posedge mclk); while (apbRsp.pready !== 1'b1);
        rd  = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq.psel    <= 1'b0;
        apbReq.penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    task automatic test_reset;
        apb(1'b1, fantp_pkg::QLO_IDX, 32'h4);
        apb(1'b1, fantp_pkg::QHI_IDX, 32'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, fantp_pkg::VAL_IDX[i], 32'h0);
            chk("value reset", 32'hff, rd);
            apb(1'b0, fantp_pkg::FREQ_IDX[i], 32'h0);
            chk("freq reset", {24'h0, fantp_pkg::FREQ_RST}, rd);
        end
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, fantp_pkg::DIV_IDX[i], 32'h0);
            chk("divisor reset", 32'h1, rd);
        end
        apb(1'b0, 10'h050, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        $display("test reset done");
    endtask : test_reset

    task automatic test_tach;
        apb(1'b1, fantp_pkg::DIV_IDX[1], 32'h0);
        repeat (4200) @(posedge mclk);
        apb(1'b1, fantp_pkg::CNT_IDX[0], 32'h55);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, fantp_pkg::CNT_IDX[i], 32'h0);
            chk("fan count", (i == 1) ? 32'h28 : 32'(10 * (i + 1)), rd);
        end
        $display("test tach done");
    endtask : test_tach

    task automatic test_pwm;
        int hi0;
        int hi3;
        hi0 = 0;
        hi3 = 0;
        apb(1'b1, fantp_pkg::FREQ_IDX[0], 32'h0);
        apb(1'b1, fantp_pkg::VAL_IDX[0], 32'h80);
        // Let the new step length settle before counting two whole periods
        repeat (6200) @(posedge mclk);
        repeat (2040) begin
            @(negedge mclk);
            hi0 += int'(pwmOut[0]);
            hi3 += int'(pwmOut[3]);
        end
        @(posedge mclk);
        chk("duty high cycles", 32'd1024, hi0);
        chk("full duty", 32'd2040, hi3);
        $display("test pwm done");
    endtask : test_pwm

    task automatic test_dc;
        apb(1'b1, fantp_pkg::MODE_IDX, 32'h2);
        apb(1'b1, fantp_pkg::VAL_IDX[1], 32'ha7);
        repeat (4) @(negedge mclk);
        chk("dc code", 32'h29, {26'h0, dacCode[1]});
        chk("dc pin low", 32'h0, {31'h0, pwmOut[1]});
        chk("pwm fan no code", 32'h0, {26'h0, dacCode[0]});
        @(posedge mclk);
        $display("test dc done");
    endtask : test_dc

    task automatic test_temp;
        apb(1'b1, fantp_pkg::TBASE_IDX[2], 32'h64);
        for (int n = 0; n < 4000 && fanTemp[2] !== 8'h55; n++) @(posedge mclk);
        apb(1'b0, fantp_pkg::TEMP_IDX[2], 32'h0);
        chk("offset temp", 32'h55, rd);
        chk("offset pin", 32'h55, {24'h0, fanTemp[2]});
        apb(1'b0, fantp_pkg::RAWLO_IDX, 32'h0);
        chk("raw low", 32'h40, rd);
        apb(1'b0, fantp_pkg::RAWHI_IDX, 32'h0);
        chk("raw high", 32'hfc, rd);
        apb(1'b0, fantp_pkg::STAT_IDX, 32'h0);
        chk("reading valid", 32'h1, {31'h0, rd[0]});
        $display("test temp done");
    endtask : test_temp

    task automatic test_bridge;
        apb(1'b1, fantp_pkg::BRG_IDX, 32'h1);
        for (int n = 0; n < 3000; n++) begin
            apb(1'b0, fantp_pkg::STAT_IDX, 32'h0);
            if (rd[7:4] === 4'h8) break;
        end
        chk("bridge state", 32'h8, {28'h0, rd[7:4]});
        hostDrv <= 1'b1;
        repeat (8) @(negedge mclk);
        chk("bridged drive", 32'h3, {30'h0, peciOe, peciOut});
        @(posedge mclk);
        hostDrv <= 1'b0;
        repeat (8) @(negedge mclk);
        chk("bridged release", 32'h0, {30'h0, peciOe, sbOe});
        @(posedge mclk);
        apb(1'b1, fantp_pkg::BRG_IDX, 32'h0);
        $display("test bridge done");
    endtask : test_bridge

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    // About 14000 cycles are needed; the ceiling leaves ample margin
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            final_report();
        end
    end

    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        test_reset();
        test_tach();
        test_pwm();
        test_dc();
        test_temp();
        test_bridge();
        final_report();
    end
endmodule : tb_fan_tach_pwm_control
